/* fsel_log_mem.sv */
// Stored fault log memory: one write port, one read port with registered data
`timescale 1ns/1ps
module fsel_log_mem
  import fsel_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               we,
  input  wire logic [ADDR_W-1:0]  waddr,
  input  wire logic [ENTRY_W-1:0] wdata,
  input  wire logic [ADDR_W-1:0]  raddr,
  output logic      [ENTRY_W-1:0] rdata
);

  logic [ENTRY_W-1:0] mem [MEM_DEPTH];

  always_ff @(posedge pclk) begin
    if (we) mem[waddr] <= wdata;
  end

  always_ff @(posedge pclk) begin
    rdata <= mem[raddr];
  end

endmodule : fsel_log_mem

/* fsel_pkg.sv */
// Constants, register map and helper functions of the fault status event logger
// Summary of operation
// RULE_01: Each fault category keeps only its first ten status changes, in slots zero to nine; common equipment keeps eight, in slots two to nine, until a clear.
// RULE_02: Every stored change carries the time and date at which it happened.
// RULE_03: One clear command empties every slot of every category at once.
// RULE_04: A power-on reset empties the whole log.
// RULE_05: At power-up the saved last-known time is logged as common-equipment slot zero.
// RULE_06: At power-up the power-up time is logged as common-equipment slot one.
// RULE_07: Entries fill in time order from slot zero, and changes after slot nine are dropped.
// RULE_08: A slot that holds no entry reads back as no fault.
// RULE_09: While the selected transmit clock activity alarm is on, transmit timing uses the internal clock.
// RULE_10: Transmit and receive interface groups are reported only when the overhead unit is fitted.
// RULE_11: The modulator group holds seven flags.
// RULE_12: The demodulator group holds eight flags.
// RULE_13: The common equipment group holds battery, three rails, controller and interface flags.
// RULE_14: The receive interface group holds five flags.
// RULE_15: The transmit interface group holds a clock loop flag and a clock activity flag.
// RULE_16: Each reported flag reads as a plus sign when present and a minus sign when absent.
// RULE_17: A change is any flag of a group differing from its last sample, and the whole group is logged.
package fsel_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned NUM_CAT     = 5;
  localparam int unsigned NUM_SLOTS   = 10;
  localparam int unsigned FLAG_W      = 8;
  localparam int unsigned TIME_W      = 32;
  localparam int unsigned ENTRY_W     = FLAG_W + TIME_W;
  localparam int unsigned CAT_W       = 3;
  localparam int unsigned SLOT_W      = 4;
  localparam int unsigned ADDR_W      = CAT_W + SLOT_W;
  localparam int unsigned MEM_DEPTH   = 80;
  localparam int unsigned MOD_W       = 7;
  localparam int unsigned DMD_W       = 8;
  localparam int unsigned CEQ_W       = 6;
  localparam int unsigned TXI_W       = 2;
  localparam int unsigned RXI_W       = 5;

  // ****************************************
  // Categories and flag positions
  // ****************************************
  localparam logic [2:0] CAT_MOD = 3'h0;
  localparam logic [2:0] CAT_DMD = 3'h1;
  localparam logic [2:0] CAT_CEQ = 3'h2;
  localparam logic [2:0] CAT_TXI = 3'h3;
  localparam logic [2:0] CAT_RXI = 3'h4;
  localparam int unsigned TXI_PLL_BIT     = 0;
  localparam int unsigned TXI_CLK_ACT_BIT = 1;
  localparam logic [3:0] SLOT_PWR_DOWN = 4'h0;
  localparam logic [3:0] SLOT_PWR_UP   = 4'h1;
  localparam logic [3:0] SLOT_LIMIT    = 4'ha;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h08;
  localparam logic [7:0] REG_LIVE_A    = 8'h0c;
  localparam logic [7:0] REG_LIVE_B    = 8'h10;
  localparam logic [7:0] REG_TEXT_SEL  = 8'h14;
  localparam logic [7:0] REG_TEXT_LO   = 8'h18;
  localparam logic [7:0] REG_TEXT_HI   = 8'h1c;
  localparam logic [7:0] REG_LOG_SEL   = 8'h20;
  localparam logic [7:0] REG_LOG_TIME  = 8'h24;
  localparam logic [7:0] REG_LOG_FLAGS = 8'h28;
  localparam logic [7:0] REG_LOG_COUNT = 8'h2c;

  localparam int unsigned CTRL_CLEAR_BIT   = 0;
  localparam int unsigned LIVE_DMD_LSB     = 8;
  localparam int unsigned LIVE_CEQ_LSB     = 16;
  localparam int unsigned LIVE_RXI_LSB     = 8;
  localparam int unsigned LIVE_FITTED_BIT  = 16;
  localparam int unsigned LIVE_INTCLK_BIT  = 17;
  localparam int unsigned LOG_CAT_LSB      = 8;
  localparam int unsigned LOG_VALID_BIT    = 31;
  localparam int unsigned IRQ_W            = 7;
  localparam int unsigned IRQ_FULL_BIT     = 5;
  localparam int unsigned IRQ_FALLBACK_BIT = 6;
  localparam logic [6:0]  IRQ_MASK_RST     = 7'h00;

  localparam logic [7:0] CHAR_PLUS  = 8'h2b;
  localparam logic [7:0] CHAR_MINUS = 8'h2d;
  localparam logic [7:0] CHAR_SPACE = 8'h20;

  typedef enum logic [1:0] {
    ST_PWR_DOWN = 2'b00,
    ST_PWR_UP   = 2'b01,
    ST_RUN      = 2'b10
  } fsel_state_t;

  // Memory address of a category slot
  function automatic logic [ADDR_W-1:0] fsel_addr(input logic [CAT_W-1:0]  cat,
                                                  input logic [SLOT_W-1:0] slot);
    fsel_addr = {cat, slot};
  endfunction : fsel_addr

  // Displayed character of one flag position
  function automatic logic [7:0] fsel_flag_char(input logic [FLAG_W-1:0] flags,
                                                input logic [3:0]        width,
                                                input int unsigned       pos);
    if (pos >= int'(width)) fsel_flag_char = CHAR_SPACE;
    else if (flags[pos]) fsel_flag_char = CHAR_PLUS;
    else fsel_flag_char = CHAR_MINUS;
  endfunction : fsel_flag_char

endpackage : fsel_pkg

/* fsel_rtc_model.sv */
// Real-time clock and nonvolatile time store beside the logger
`timescale 1ns/1ps
module fsel_rtc_model
  import fsel_pkg::*;
#(
  parameter logic [TIME_W-1:0] NV_INIT = 32'h0000_0100
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [TIME_W-1:0] nv_time_store,
  output logic      [TIME_W-1:0] rtc_time_date,
  output logic      [TIME_W-1:0] nv_last_time
);
  // Clock keeps running through a controller reset
  initial begin
    rtc_time_date = 32'h0001_0000;
    forever @(posedge pclk) rtc_time_date <= rtc_time_date + 32'h1;
  end
  // Last time is saved at the power-down moment only
  initial begin
    nv_last_time = NV_INIT;
    forever @(negedge presetn) begin
      if (nv_time_store != 32'h0) nv_last_time <= nv_time_store;
    end
  end
endmodule : fsel_rtc_model

/* fsel_sync.sv */
// Two-stage synchroniser for asynchronous fault inputs
`timescale 1ns/1ps
module fsel_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : fsel_sync

/* fsel_top.sv */
// Fault status event logger with APB register access
`timescale 1ns/1ps
module fsel_top
  import fsel_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [MOD_W-1:0]  mod_fault_in,
  input  wire logic [DMD_W-1:0]  dmd_fault_in,
  input  wire logic [CEQ_W-1:0]  common_equipment_fault_in,
  input  wire logic [TXI_W-1:0]  transmit_interface_fault_in,
  input  wire logic [RXI_W-1:0]  receive_interface_fault_in,
  input  wire logic              ovh_unit_fitted,
  input  wire logic [TIME_W-1:0] rtc_time_date,
  input  wire logic [TIME_W-1:0] nv_last_time,
  output logic      [TIME_W-1:0] nv_time_store,
  output logic                   tx_timing_internal,
  output logic                   irq
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [MOD_W-1:0] mod_s;
  logic [DMD_W-1:0] dmd_s;
  logic [CEQ_W-1:0] ceq_s;
  logic [TXI_W-1:0] txi_s;
  logic [RXI_W-1:0] rxi_s;
  logic             fitted_s;

  fsel_sync #(.W(MOD_W)) u_sync_mod (.pclk(pclk), .presetn(presetn), .d(mod_fault_in), .q(mod_s));
  fsel_sync #(.W(DMD_W)) u_sync_dmd (.pclk(pclk), .presetn(presetn), .d(dmd_fault_in), .q(dmd_s));
  fsel_sync #(.W(CEQ_W)) u_sync_ceq (.pclk(pclk), .presetn(presetn),
                                     .d(common_equipment_fault_in), .q(ceq_s));
  fsel_sync #(.W(TXI_W)) u_sync_txi (.pclk(pclk), .presetn(presetn),
                                     .d(transmit_interface_fault_in), .q(txi_s));
  fsel_sync #(.W(RXI_W)) u_sync_rxi (.pclk(pclk), .presetn(presetn),
                                     .d(receive_interface_fault_in), .q(rxi_s));
  fsel_sync #(.W(1)) u_sync_fit (.pclk(pclk), .presetn(presetn),
                                 .d(ovh_unit_fitted), .q(fitted_s));

  // ****************************************
  // Fault groups
  // ****************************************
  logic [FLAG_W-1:0] grp_now [NUM_CAT];
  logic [3:0]        grp_width [NUM_CAT];

  always_comb begin
    grp_now[CAT_MOD] = FLAG_W'(mod_s);                            // RULE_11
    grp_now[CAT_DMD] = FLAG_W'(dmd_s);                            // RULE_12
    grp_now[CAT_CEQ] = FLAG_W'(ceq_s);                            // RULE_13
    grp_now[CAT_TXI] = fitted_s ? FLAG_W'(txi_s) : '0;            // RULE_15 RULE_10
    grp_now[CAT_RXI] = fitted_s ? FLAG_W'(rxi_s) : '0;            // RULE_14 RULE_10
    grp_width[CAT_MOD] = 4'(MOD_W);
    grp_width[CAT_DMD] = 4'(DMD_W);
    grp_width[CAT_CEQ] = 4'(CEQ_W);
    grp_width[CAT_TXI] = fitted_s ? 4'(TXI_W) : 4'h0;             // RULE_10
    grp_width[CAT_RXI] = fitted_s ? 4'(RXI_W) : 4'h0;             // RULE_10
  end

  // ****************************************
  // Change detection and pending snapshots
  // ****************************************
  logic [FLAG_W-1:0] prev_r  [NUM_CAT];
  logic [FLAG_W-1:0] snap_r  [NUM_CAT];
  logic [TIME_W-1:0] stamp_r [NUM_CAT];
  logic [NUM_CAT-1:0] chg;
  logic [NUM_CAT-1:0] pend_r;
  logic [NUM_CAT-1:0] served;
  logic               clear_cmd;
  fsel_state_t        state_r;

  always_comb begin
    for (int c = 0; c < NUM_CAT; c++) begin
      chg[c] = (grp_now[c] != prev_r[c]);                         // RULE_17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NUM_CAT; c++) begin
        prev_r[c]  <= '0;
        snap_r[c]  <= '0;
        stamp_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CAT; c++) begin
        prev_r[c] <= grp_now[c];
        if (chg[c]) begin
          snap_r[c]  <= grp_now[c];                               // RULE_17
          stamp_r[c] <= rtc_time_date;                            // RULE_02
        end
      end
    end
  end

  // New change wins over the service of an older one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pend_r <= '0;
    else if (clear_cmd) pend_r <= chg;
    else pend_r <= (pend_r & ~served) | chg;                      // RULE_17
  end

  // ****************************************
  // Log writer and power-up sequence
  // ****************************************
  logic [SLOT_W-1:0]  cnt_r [NUM_CAT];
  logic [NUM_CAT*NUM_SLOTS-1:0] valid_r;
  logic [CAT_W-1:0]   wcat;
  logic               wany;
  logic               wfull;
  logic               mem_we;
  logic [ADDR_W-1:0]  mem_waddr;
  logic [ENTRY_W-1:0] mem_wdata;

  always_comb begin
    wcat = '0;
    wany = 1'b0;
    for (int c = NUM_CAT - 1; c >= 0; c--) begin
      if (pend_r[c]) begin
        wcat = CAT_W'(c);
        wany = 1'b1;
      end
    end
  end

  always_comb begin
    served    = '0;
    mem_we    = 1'b0;
    wfull     = 1'b0;
    mem_waddr = fsel_addr(wcat, cnt_r[wcat]);
    mem_wdata = {snap_r[wcat], stamp_r[wcat]};
    case (state_r)
      ST_PWR_DOWN: begin
        mem_we    = 1'b1;
        mem_waddr = fsel_addr(CAT_CEQ, SLOT_PWR_DOWN);            // RULE_05
        mem_wdata = {grp_now[CAT_CEQ], nv_last_time};             // RULE_05
      end
      ST_PWR_UP: begin
        mem_we    = 1'b1;
        mem_waddr = fsel_addr(CAT_CEQ, SLOT_PWR_UP);              // RULE_06
        mem_wdata = {grp_now[CAT_CEQ], rtc_time_date};            // RULE_06
      end
      ST_RUN: begin
        if (wany && !clear_cmd) begin
          served[wcat] = 1'b1;
          mem_we = (cnt_r[wcat] < SLOT_LIMIT);                    // RULE_01 RULE_07
          wfull  = !mem_we;                                       // RULE_07
        end
      end
      default: begin
        mem_we = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_r <= ST_PWR_DOWN;
    else begin
      case (state_r)
        ST_PWR_DOWN: state_r <= ST_PWR_UP;
        ST_PWR_UP:   state_r <= ST_RUN;
        ST_RUN:      state_r <= ST_RUN;
        default:     state_r <= ST_PWR_DOWN;
      endcase
    end
  end

  // Counts and valid bits; clear empties everything in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_r <= '0;                                              // RULE_04
      for (int c = 0; c < NUM_CAT; c++) cnt_r[c] <= '0;
    end else if (clear_cmd) begin
      valid_r <= '0;                                              // RULE_03
      for (int c = 0; c < NUM_CAT; c++) cnt_r[c] <= '0;
    end else if (mem_we) begin
      valid_r[int'(mem_waddr[ADDR_W-1:SLOT_W]) * NUM_SLOTS + int'(mem_waddr[SLOT_W-1:0])] <= 1'b1;
      cnt_r[mem_waddr[ADDR_W-1:SLOT_W]] <= mem_waddr[SLOT_W-1:0] + 4'h1;  // RULE_07
    end
  end

  logic [CAT_W-1:0]   log_cat_r;
  logic [SLOT_W-1:0]  log_slot_r;
  logic [ENTRY_W-1:0] mem_rdata;

  fsel_log_mem u_mem (
    .pclk  (pclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (fsel_addr(log_cat_r, log_slot_r)),
    .rdata (mem_rdata)
  );

  // ****************************************
  // Transmit clock fallback and NV time
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_timing_internal <= 1'b0;
      nv_time_store      <= '0;
    end else begin
      tx_timing_internal <= grp_now[CAT_TXI][TXI_CLK_ACT_BIT];    // RULE_09
      nv_time_store      <= rtc_time_date;                        // RULE_05
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic                  acc;
  logic                  wr_ok;
  logic                  hit;
  logic [31:0]           rd_nxt;
  logic [IRQ_W-1:0]      irq_stat_r;
  logic [IRQ_W-1:0]      irq_mask_r;
  logic [CAT_W-1:0]      text_sel_r;
  logic [IRQ_W-1:0]      irq_ev;
  logic                  log_ok;
  logic [3:0]            tw;

  assign acc       = psel && penable && !pready;
  assign wr_ok     = psel && penable && pready && pwrite && !pslverr;
  assign clear_cmd = wr_ok && (paddr == REG_CTRL) && pwdata[CTRL_CLEAR_BIT];  // RULE_03
  assign log_ok    = (log_cat_r < CAT_W'(NUM_CAT)) && (log_slot_r < SLOT_LIMIT) &&
                     valid_r[int'(log_cat_r) * NUM_SLOTS + int'(log_slot_r)];
  assign tw        = (text_sel_r < CAT_W'(NUM_CAT)) ? grp_width[text_sel_r] : 4'h0;

  always_comb begin
    hit    = 1'b1;
    rd_nxt = '0;
    case (paddr)
      REG_CTRL:     rd_nxt = '0;
      REG_IRQ_STAT: rd_nxt = 32'(irq_stat_r);
      REG_IRQ_MASK: rd_nxt = 32'(irq_mask_r);
      REG_LIVE_A:   rd_nxt = 32'(grp_now[CAT_MOD]) | (32'(grp_now[CAT_DMD]) << LIVE_DMD_LSB) |
                             (32'(grp_now[CAT_CEQ]) << LIVE_CEQ_LSB);
      REG_LIVE_B: begin
        rd_nxt = 32'(grp_now[CAT_TXI]) | (32'(grp_now[CAT_RXI]) << LIVE_RXI_LSB);
        rd_nxt[LIVE_FITTED_BIT] = fitted_s;
        rd_nxt[LIVE_INTCLK_BIT] = tx_timing_internal;
      end
      REG_TEXT_SEL: rd_nxt = 32'(text_sel_r);
      REG_TEXT_LO: begin
        for (int i = 0; i < 4; i++)
          rd_nxt[i*8 +: 8] = fsel_flag_char(grp_now[text_sel_r], tw, i);       // RULE_16
      end
      REG_TEXT_HI: begin
        for (int i = 0; i < 4; i++)
          rd_nxt[i*8 +: 8] = fsel_flag_char(grp_now[text_sel_r], tw, i + 4);   // RULE_16
      end
      REG_LOG_SEL:  rd_nxt = 32'(log_slot_r) | (32'(log_cat_r) << LOG_CAT_LSB);
      REG_LOG_TIME: rd_nxt = log_ok ? mem_rdata[TIME_W-1:0] : '0;              // RULE_08
      REG_LOG_FLAGS: begin
        rd_nxt = log_ok ? 32'(mem_rdata[ENTRY_W-1:TIME_W]) : '0;               // RULE_08
        rd_nxt[LOG_VALID_BIT] = log_ok;
      end
      REG_LOG_COUNT: begin
        for (int c = 0; c < NUM_CAT; c++) rd_nxt[c*SLOT_W +: SLOT_W] = cnt_r[c];
      end
      default:      hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= acc;
      pslverr <= acc && !hit;
      prdata  <= (acc && !pwrite && hit) ? rd_nxt : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= IRQ_MASK_RST;
      text_sel_r <= '0;
      log_cat_r  <= '0;
      log_slot_r <= '0;
    end else if (wr_ok) begin
      if (paddr == REG_IRQ_MASK) irq_mask_r <= pwdata[IRQ_W-1:0];
      if (paddr == REG_TEXT_SEL) text_sel_r <= pwdata[CAT_W-1:0];
      if (paddr == REG_LOG_SEL) begin
        log_slot_r <= pwdata[SLOT_W-1:0];
        log_cat_r  <= pwdata[LOG_CAT_LSB +: CAT_W];
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  always_comb begin
    irq_ev = '0;
    if (mem_we && state_r == ST_RUN) irq_ev[mem_waddr[ADDR_W-1:SLOT_W]] = 1'b1;
    irq_ev[IRQ_FULL_BIT]     = wfull;
    irq_ev[IRQ_FALLBACK_BIT] = grp_now[CAT_TXI][TXI_CLK_ACT_BIT] && !tx_timing_internal;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_stat_r <= '0;
    else if (wr_ok && paddr == REG_IRQ_STAT) irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W-1:0]) | irq_ev;
    else irq_stat_r <= irq_stat_r | irq_ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else irq <= |(irq_stat_r & irq_mask_r);
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_count_bound: assert property (cnt_r[CAT_MOD] <= SLOT_LIMIT && cnt_r[CAT_CEQ] <= SLOT_LIMIT)  // RULE_01
    else $error("slot count above ten");
  a_full_drop: assert property (state_r == ST_RUN && served != 0 && cnt_r[wcat] == SLOT_LIMIT
    |-> !mem_we ##1 cnt_r[$past(wcat)] == SLOT_LIMIT)  // RULE_07
    else $error("write past last slot");
  a_clear_all: assert property (clear_cmd |=> valid_r == '0 && cnt_r[CAT_CEQ] == '0)  // RULE_03
    else $error("clear left entries");
  a_reset_empty: assert property (state_r == ST_PWR_DOWN |-> valid_r == '0)  // RULE_04
    else $error("log not empty after reset");
  a_pwr_down_slot: assert property (state_r == ST_PWR_DOWN |-> mem_we &&
    mem_wdata[TIME_W-1:0] == nv_last_time ##1 state_r == ST_PWR_UP)  // RULE_05
    else $error("power-down entry missing");
  a_pwr_up_slot: assert property (state_r == ST_PWR_UP && !clear_cmd |=>
    cnt_r[CAT_CEQ] == 4'h2 && state_r == ST_RUN)  // RULE_06
    else $error("power-up entry missing");
  a_stamp_time: assert property (chg[CAT_MOD] |=> stamp_r[CAT_MOD] == $past(rtc_time_date))  // RULE_02
    else $error("stamp not taken with change");
  a_empty_read: assert property (acc && !pwrite && paddr == REG_LOG_FLAGS && !log_ok
    |=> pready && prdata == '0)  // RULE_08
    else $error("empty slot not no fault");
  a_clk_fallback: assert property (grp_now[CAT_TXI][TXI_CLK_ACT_BIT] |=> tx_timing_internal)  // RULE_09
    else $error("no internal clock fallback");
  a_unfitted_mask: assert property (!fitted_s |-> grp_now[CAT_TXI] == '0 &&
    grp_now[CAT_RXI] == '0 && grp_width[CAT_TXI] == 4'h0 ##1 !tx_timing_internal)  // RULE_10
    else $error("interface group shown unfitted");
  a_change_pend: assert property (chg != '0 && !clear_cmd |=>
    (pend_r & $past(chg)) == $past(chg))  // RULE_17
    else $error("change not pending");
  a_sign_text: assert property (acc && !pwrite && paddr == REG_TEXT_LO && tw != 4'h0
    |=> prdata[7:0] == ($past(grp_now[text_sel_r][0]) ? CHAR_PLUS : CHAR_MINUS))  // RULE_16
    else $error("wrong sign character");

  c_log_full: cover property (wfull);
  c_clear: cover property (clear_cmd ##1 mem_we);
  c_fallback: cover property ($rose(tx_timing_internal));
  c_irq: cover property ($rose(irq));

endmodule : fsel_top

/* tb_top.sv */
// Self-checking testbench of the fault status event logger
`timescale 1ns/1ps
module tb_top
  import fsel_pkg::*;
;
  localparam logic [31:0] NV0 = 32'h0000_0100;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rv;
  logic pready, pslverr, irq, tx_timing_internal, ovh_unit_fitted = 0;
  logic [MOD_W-1:0] mod_fault_in = 0;
  logic [DMD_W-1:0] dmd_fault_in = 0;
  logic [CEQ_W-1:0] common_equipment_fault_in = 0;
  logic [TXI_W-1:0] transmit_interface_fault_in = 0;
  logic [RXI_W-1:0] receive_interface_fault_in = 0;
  logic [TIME_W-1:0] rtc_time_date, nv_last_time, nv_time_store;
  int bad_count = 0, tests_run = 0;
  always #5 pclk = ~pclk;
  fsel_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mod_fault_in, .dmd_fault_in,
    .common_equipment_fault_in, .transmit_interface_fault_in,
    .receive_interface_fault_in, .ovh_unit_fitted, .rtc_time_date,
    .nv_last_time, .nv_time_store, .tx_timing_internal, .irq);
  fsel_rtc_model #(.NV_INIT(NV0)) env (.pclk, .presetn, .nv_time_store,
    .rtc_time_date, .nv_last_time);
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task chk(string n, logic [31:0] g, logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rv = prdata;
    er = pslverr;
    if (n >= 50) begin
      bad_count++;
      stop_test;
    end
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask : apb
  task rdlog(logic [2:0] c, logic [3:0] s, logic [7:0] a);
    apb(1, REG_LOG_SEL, {21'h0, c, 4'h0, s});
    apb(0, a, 0);
  endtask : rdlog
  task do_reset;
    presetn <= 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    repeat (5) @(posedge pclk);
  endtask : do_reset
  // ****************************************
  // Scenarios
  // ****************************************
  task t_powerup;
    apb(0, REG_LOG_COUNT, 0); chk("start count", rv, 32'h200);
    rdlog(CAT_CEQ, SLOT_PWR_DOWN, REG_LOG_TIME); chk("down time", rv, NV0);
    apb(0, REG_LOG_FLAGS, 0); chk("down flags", rv, 32'h8000_0000);
    rdlog(CAT_CEQ, SLOT_PWR_UP, REG_LOG_TIME); chk("up time", rv > NV0, 1);
    chk("nv copy", nv_time_store, rtc_time_date - 32'h1);
    rdlog(CAT_CEQ, 4'h2, REG_LOG_FLAGS); chk("empty slot", rv, 0);
  endtask : t_powerup
  task t_fill;
    logic [31:0] tp;
    tp = 0;
    for (int k = 0; k < 11; k++) begin
      mod_fault_in[0] <= ~mod_fault_in[0];
      repeat (12) @(posedge pclk);
    end
    apb(0, REG_LOG_COUNT, 0); chk("mod count", rv[3:0], 4'ha);
    apb(0, REG_LIVE_A, 0); chk("live a", rv, 32'h1);
    for (int k = 0; k < 10; k++) begin
      rdlog(CAT_MOD, k[3:0], REG_LOG_FLAGS); chk("flags", rv, {1'b1, 30'h0, ~k[0]});
      apb(0, REG_LOG_TIME, 0); chk("time order", rv > tp, 1);
      tp = rv;
    end
    rdlog(CAT_MOD, SLOT_LIMIT, REG_LOG_FLAGS); chk("past last", rv, 0);
    apb(0, REG_IRQ_STAT, 0); chk("status", rv & 32'h21, 32'h21);
    chk("masked irq", irq, 0);
    apb(1, REG_IRQ_MASK, 32'h20); repeat (2) @(posedge pclk);
    chk("irq on", irq, 1);
    apb(1, REG_IRQ_STAT, 32'h20); repeat (2) @(posedge pclk);
    chk("irq off", irq, 0);
  endtask : t_fill
  task t_fallback;
    ovh_unit_fitted <= 1; transmit_interface_fault_in <= 2'h3;
    receive_interface_fault_in <= 5'h11; common_equipment_fault_in <= 6'h20;
    repeat (6) @(posedge pclk);
    chk("fallback", tx_timing_internal, 1);
    apb(0, REG_LIVE_B, 0); chk("live b", rv, 32'h0003_1103);
    apb(0, REG_IRQ_STAT, 0); chk("event bits", rv & 32'h5c, 32'h5c);
    apb(1, REG_TEXT_SEL, CAT_RXI); apb(0, REG_TEXT_LO, 0);
    chk("rx text", rv, 32'h2d2d_2d2b);
    apb(0, REG_TEXT_HI, 0); chk("rx text hi", rv, 32'h2020_202b);
    apb(1, REG_TEXT_SEL, CAT_CEQ); apb(0, REG_TEXT_HI, 0);
    chk("ceq text hi", rv, 32'h2020_2b2d);
    apb(1, REG_TEXT_SEL, CAT_TXI); apb(0, REG_TEXT_LO, 0);
    chk("tx text", rv, 32'h2020_2b2b);
    apb(1, REG_TEXT_SEL, CAT_MOD); apb(0, REG_TEXT_LO, 0);
    chk("mod text", rv, 32'h2d2d_2d2b);
    apb(0, REG_TEXT_HI, 0); chk("mod text hi", rv, 32'h202d_2d2d);
    apb(1, REG_TEXT_SEL, CAT_DMD); apb(0, REG_TEXT_HI, 0);
    chk("dmd text hi", rv, 32'h2d2d_2d2d);
    ovh_unit_fitted <= 0;
    repeat (6) @(posedge pclk);
    chk("no fallback", tx_timing_internal, 0);
    apb(0, REG_LIVE_B, 0); chk("live b off", rv, 0);
    apb(1, REG_TEXT_SEL, CAT_TXI); apb(0, REG_TEXT_LO, 0);
    chk("tx hidden", rv, 32'h2020_2020);
  endtask : t_fallback
  task t_clear;
    apb(1, REG_CTRL, 1); apb(0, REG_LOG_COUNT, 0); chk("cleared", rv, 0);
    rdlog(CAT_CEQ, 4'h0, REG_LOG_FLAGS); chk("cleared slot", rv, 0);
    apb(1, 8'h30, 32'hffff_ffff); chk("unmapped err", er, 1);
    apb(0, 8'h30, 0); chk("unmapped data", rv, 0);
    mod_fault_in <= 0; transmit_interface_fault_in <= 0;
    receive_interface_fault_in <= 0; common_equipment_fault_in <= 0;
    do_reset;
    apb(0, REG_LOG_COUNT, 0); chk("reset count", rv, 32'h200);
    rdlog(CAT_CEQ, SLOT_PWR_DOWN, REG_LOG_TIME); chk("saved time", rv, nv_last_time);
    chk("time kept", nv_last_time > NV0, 1);
  endtask : t_clear
  initial begin
    do_reset;
    t_powerup;
    t_fill;
    t_fallback;
    t_clear;
    stop_test;
  end
endmodule : tb_top
